/* pbh_patch_defs.vh */
`ifndef PBH_PATCH_DEFS_VH
`define PBH_PATCH_DEFS_VH

// Model-specific register addresses.
`define PBH_MSR_PLATFORM       32'h0000_0017
`define PBH_MSR_TRIGGER        32'h0000_0079
`define PBH_MSR_REVISION       32'h0000_008b

// Platform type code field inside its 64-bit register.
`define PBH_PLAT_LSB           50
`define PBH_PLAT_MSB           52
`define PBH_PLAT_W             3

// Block geometry in bytes, plus the index of the last four-byte double word.
`define PBH_DW_BYTES           32'h0000_0004
`define PBH_BLOCK_BYTES        12'h800
`define PBH_HDR_BYTES          12'h030
`define PBH_PAYLOAD_BYTES      12'h7d0
`define PBH_LAST_DW            9'h1ff

// Header field double-word indexes (byte offset divided by four).
`define PBH_IDX_HDR_VER        9'h000
`define PBH_IDX_REVISION       9'h001
`define PBH_IDX_DATE           9'h002
`define PBH_IDX_SIGNATURE      9'h003
`define PBH_IDX_CHECKSUM       9'h004
`define PBH_IDX_LOADER_VER     9'h005
`define PBH_IDX_MATCH_MASK     9'h006
`define PBH_IDX_RSVD_FIRST     9'h007
`define PBH_IDX_RSVD_LAST      9'h00b

// Defined header and loader versions.
`define PBH_HDR_VER_1          32'h0000_0001
`define PBH_LOADER_VER_1       32'h0000_0001

// Meaningful width of the platform match mask.
`define PBH_MASK_W             8

// Load result codes.
`define PBH_RES_OK             3'h0
`define PBH_RES_BAD_LENGTH     3'h1
`define PBH_RES_BAD_SUM        3'h2
`define PBH_RES_BAD_VERSION    3'h3
`define PBH_RES_BAD_STEPPING   3'h4
`define PBH_RES_BAD_PLATFORM   3'h5

// Loader state codes, one-hot.
`define PBH_ST_IDLE            4'h1
`define PBH_ST_FETCH           4'h2
`define PBH_ST_CHECK           4'h4
`define PBH_ST_DONE            4'h8

`endif

/* pbh_match.v */
`timescale 1ns/100ps
`include "pbh_patch_defs.vh"

module pbh_match (
  // Captured header fields.
  input  wire [31:0] hdr_version,
  input  wire [31:0] loader_version,
  input  wire [31:0] target_signature,
  input  wire [31:0] match_mask,
  input  wire [31:0] block_sum,
  // Processor identity.
  input  wire [31:0] cpu_signature,
  input  wire [2:0]  platform_code,
  // Verdict.
  output reg  [2:0]  result
);

  wire [`PBH_MASK_W-1:0] mask_low;
  wire                   plat_hit;
  wire                   sig_hit;

  // Upper mask bits carry no meaning and are never looked at.
  assign mask_low = match_mask[`PBH_MASK_W-1:0];
  assign plat_hit = mask_low[platform_code];
  assign sig_hit  = (target_signature == cpu_signature);

  // A bad sum wins over everything, then format, then identity.
  always @* begin
    if (block_sum != 32'h0000_0000) begin
      result = `PBH_RES_BAD_SUM;
    end else if (hdr_version != `PBH_HDR_VER_1 ||
                 loader_version != `PBH_LOADER_VER_1) begin
      result = `PBH_RES_BAD_VERSION;
    end else if (!sig_hit) begin
      result = `PBH_RES_BAD_STEPPING;
    end else if (!plat_hit) begin
      result = `PBH_RES_BAD_PLATFORM;
    end else begin
      result = `PBH_RES_OK;
    end
  end

endmodule // pbh_match

/* pbh_patch_loader.v */
// How it works
// - A block for another stepping is refused and the load fails.
// - Platform type code register sits at 017H and ignores writes.
// - That register is 64 bits, read only as one whole quadword.
// - Platform code lives in bits 52:50; all other bits are reserved.
// - The platform code value picks which match mask bit applies.
// - A block is exactly 2048 bytes; anything else is invalid.
// - Bytes 0 to 47 are the header, 2000 payload bytes follow.
// - Header version word at offset 0; first format is 00000001H.
// - Revision word at offset 4 becomes the reported patch signature.
// - Target signature at offset 12 must equal the processor identity.
// - All 512 double words must sum to zero; checksum at offset 16.
// - Loader version word at offset 20; first version is 00000001h.
// - Match mask at offset 24; only its low eight bits count.
// - Applicable only when selected mask bit and signature both match.
// - Bytes 28 to 47 are reserved and carry no meaning.
// - The block is only data; nothing in it is ever executed.
// - Writing register 79H loads the block at the accumulator address.
// - Identify operation deposits active revision in 08BH if active.
`timescale 1ns/100ps
`include "pbh_patch_defs.vh"

module pbh_patch_loader (
  // Clock and reset.
  input  wire        mclk,
  input  wire        nrst,
  // Model-specific register read and write operations.
  input  wire        msr_rd,
  input  wire        msr_wr,
  input  wire [31:0] msr_addr,
  input  wire [63:0] msr_wdata,
  output reg  [63:0] msr_rdata,
  output reg         msr_ack,
  output reg         msr_fault,
  // Processor identify operation and own identity.
  input  wire        ident_op,
  input  wire [31:0] cpu_signature,
  // Platform strap pins.
  input  wire [2:0]  platform_pins,
  // Data read port toward memory.
  output reg         mem_req,
  output reg  [31:0] mem_addr,
  input  wire        mem_valid,
  input  wire        mem_err,
  input  wire [31:0] mem_data,
  // Load status.
  output reg         load_busy,
  output reg         load_done,
  output reg  [2:0]  load_result,
  output reg         patch_active,
  output reg  [31:0] active_revision
);

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [2:0]  plat_meta;
  reg  [2:0]  plat_sync;
  reg  [2:0]  platform_type_code;
  reg  [31:0] block_base;
  reg  [8:0]  dw_index;
  reg  [31:0] block_sum;
  reg  [31:0] hdr_version;
  reg  [31:0] hdr_revision;
  reg  [31:0] hdr_signature;
  reg  [31:0] hdr_loader;
  reg  [31:0] hdr_mask;
  reg  [63:0] revision_reg;
  reg         length_bad;
  wire [2:0]  verdict;
  wire [31:0] dw_le;
  wire        trigger_wr;
  wire        take_word;
  wire        trigger_go;
  wire        ident_deposit;
  reg  [63:0] next_msr_rdata;
  reg         next_msr_fault;
  reg  [63:0] next_revision;

  // Strap pins come from outside the clock domain.
  always @(posedge mclk) begin
    if (!nrst) begin
      plat_meta <= 3'h0;
      plat_sync <= 3'h0;
      platform_type_code <= 3'h0;
    end else begin
      plat_meta <= platform_pins;
      plat_sync <= plat_meta;
      platform_type_code <= plat_sync;
    end
  end

  // Memory returns byte n of the double word on lanes 8n+7:8n.
  assign dw_le = {mem_data[31:24], mem_data[23:16],
                  mem_data[15:8], mem_data[7:0]};

  assign trigger_wr = msr_wr && (msr_addr == `PBH_MSR_TRIGGER);
  assign take_word  = (state == `PBH_ST_FETCH) && mem_req && mem_valid;
  // A trigger is taken whenever no load is under way, the cycle that shows
  // load_done included; a read in the same cycle wins over it.
  assign trigger_go    = trigger_wr && !msr_rd && !load_busy;
  // Identify only deposits a revision once a block has been accepted.
  assign ident_deposit = ident_op && patch_active;

  pbh_match u_match (
    .hdr_version      (hdr_version),
    .loader_version   (hdr_loader),
    .target_signature (hdr_signature),
    .match_mask       (hdr_mask),
    .block_sum        (block_sum),
    .cpu_signature    (cpu_signature),
    .platform_code    (platform_type_code),
    .result           (verdict)
  );

  // Loader sequencing.
  always @* begin
    next_state = state;
    case (state)
      `PBH_ST_IDLE: begin
        if (trigger_go) begin
          next_state = `PBH_ST_FETCH;
        end
      end
      `PBH_ST_FETCH: begin
        if (mem_req && mem_err) begin
          next_state = `PBH_ST_CHECK;
        end else if (take_word && dw_index == `PBH_LAST_DW) begin
          next_state = `PBH_ST_CHECK;
        end
      end
      `PBH_ST_CHECK: begin
        next_state = `PBH_ST_DONE;
      end
      `PBH_ST_DONE: begin
        if (trigger_go) begin
          next_state = `PBH_ST_FETCH;
        end else begin
          next_state = `PBH_ST_IDLE;
        end
      end
      default: begin
        next_state = `PBH_ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      state <= `PBH_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Data fetch: the port only ever reads, it has no instruction path.
  always @(posedge mclk) begin
    if (!nrst) begin
      block_base <= 32'h0000_0000;
      dw_index   <= 9'h000;
      mem_req    <= 1'b0;
      mem_addr   <= 32'h0000_0000;
      length_bad <= 1'b0;
    end else if (trigger_go) begin
      // A new load restarts the fetch from the block's first double word.
      block_base <= msr_wdata[31:0];
      mem_addr   <= msr_wdata[31:0];
      mem_req    <= 1'b1;
      dw_index   <= 9'h000;
      length_bad <= 1'b0;
    end else begin
      case (state)
        `PBH_ST_FETCH: begin
          if (mem_req && mem_err) begin
            // A block that ends early is not 2048 bytes long.
            mem_req    <= 1'b0;
            length_bad <= 1'b1;
          end else if (take_word) begin
            if (dw_index == `PBH_LAST_DW) begin
              mem_req <= 1'b0;
            end else begin
              dw_index <= dw_index + 9'h001;
              mem_addr <= block_base + {21'h000000,
                          dw_index + 9'h001, 2'b00};
            end
          end
        end
        default: begin
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  // Header capture and running sum of every double word.
  always @(posedge mclk) begin
    if (!nrst) begin
      block_sum     <= 32'h0000_0000;
      hdr_version   <= 32'h0000_0000;
      hdr_revision  <= 32'h0000_0000;
      hdr_signature <= 32'h0000_0000;
      hdr_loader    <= 32'h0000_0000;
      hdr_mask      <= 32'h0000_0000;
    end else if (trigger_go) begin
      block_sum <= 32'h0000_0000;
    end else if (take_word) begin
      // Carry out of bit 31 is dropped, so the sum wraps.
      block_sum <= block_sum + dw_le;
      case (dw_index)
        `PBH_IDX_HDR_VER: begin
          hdr_version <= dw_le;
        end
        `PBH_IDX_REVISION: begin
          hdr_revision <= dw_le;
        end
        `PBH_IDX_SIGNATURE: begin
          hdr_signature <= dw_le;
        end
        `PBH_IDX_LOADER_VER: begin
          hdr_loader <= dw_le;
        end
        `PBH_IDX_MATCH_MASK: begin
          hdr_mask <= dw_le;
        end
        default: begin
          // Date, checksum, reserved area and payload only feed the sum.
          hdr_mask <= hdr_mask;
        end
      endcase
    end
  end

  // Verdict and activation of the patch.
  always @(posedge mclk) begin
    if (!nrst) begin
      load_busy       <= 1'b0;
      load_done       <= 1'b0;
      load_result     <= `PBH_RES_OK;
      patch_active    <= 1'b0;
      active_revision <= 32'h0000_0000;
    end else begin
      load_done <= 1'b0;
      if (trigger_go) begin
        load_busy <= 1'b1;
      end
      if (state == `PBH_ST_CHECK) begin
        load_busy <= 1'b0;
        load_done <= 1'b1;
        if (length_bad) begin
          load_result <= `PBH_RES_BAD_LENGTH;
        end else begin
          load_result <= verdict;
          if (verdict == `PBH_RES_OK) begin
            patch_active    <= 1'b1;
            active_revision <= hdr_revision;
          end
        end
      end
    end
  end

  // Revision register: software may preload it, identify deposits into it.
  // An identify in the same cycle as a software write wins, so firmware that
  // preloads zero and then identifies always sees the active revision.
  always @* begin
    next_revision = revision_reg;
    if (ident_deposit) begin
      next_revision = {active_revision, revision_reg[31:0]};
    end else if (msr_wr && !msr_rd &&
                 msr_addr == `PBH_MSR_REVISION) begin
      next_revision = msr_wdata;
    end
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      revision_reg <= 64'h0000_0000_0000_0000;
    end else begin
      revision_reg <= next_revision;
    end
  end

  // Register access decode: one whole quadword per operation. A read wins
  // over a write requested in the same cycle.
  always @* begin
    next_msr_rdata = 64'h0000_0000_0000_0000;
    next_msr_fault = 1'b0;
    if (msr_rd) begin
      case (msr_addr)
        `PBH_MSR_PLATFORM: begin
          next_msr_rdata[`PBH_PLAT_MSB:`PBH_PLAT_LSB] =
            platform_type_code;
        end
        `PBH_MSR_REVISION: begin
          next_msr_rdata = revision_reg;
        end
        `PBH_MSR_TRIGGER: begin
          // The trigger register can only be written.
          next_msr_fault = 1'b1;
        end
        default: begin
          next_msr_fault = 1'b1;
        end
      endcase
    end else if (msr_wr) begin
      case (msr_addr)
        `PBH_MSR_PLATFORM: begin
          // The platform code is read only; the write is dropped quietly.
          next_msr_fault = 1'b0;
        end
        `PBH_MSR_REVISION: begin
          next_msr_fault = 1'b0;
        end
        `PBH_MSR_TRIGGER: begin
          // A trigger during a load is refused and reported.
          next_msr_fault = load_busy;
        end
        default: begin
          next_msr_fault = 1'b1;
        end
      endcase
    end
  end

  // Ack, data and fault are registered and stand for one cycle.
  always @(posedge mclk) begin
    if (!nrst) begin
      msr_rdata <= 64'h0000_0000_0000_0000;
      msr_ack   <= 1'b0;
      msr_fault <= 1'b0;
    end else begin
      msr_ack   <= msr_rd || msr_wr;
      msr_rdata <= next_msr_rdata;
      msr_fault <= next_msr_fault;
    end
  end

endmodule // pbh_patch_loader

/* pbh_loader_asserts.sv */
`timescale 1ns/100ps
module pbh_loader_asserts (
  // Clock and reset.
  input wire        mclk,
  input wire        nrst,
  // Register port.
  input wire        msr_rd,
  input wire        msr_wr,
  input wire [31:0] msr_addr,
  input wire [63:0] msr_wdata,
  input wire [63:0] msr_rdata,
  input wire        msr_ack,
  input wire        msr_fault,
  input wire [2:0]  platform_pins,
  // Memory port and status.
  input wire        mem_req,
  input wire [31:0] mem_addr,
  input wire        mem_valid,
  input wire        mem_err,
  input wire        load_busy,
  input wire        load_done,
  input wire [2:0]  load_result
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire        wr_only = msr_wr && !msr_rd;
  wire [31:0] base    = msr_wdata[31:0];
  sequence s_plat_rd;
    $past(msr_rd) && $past(msr_addr) == 32'h17 && msr_ack;
  endsequence
  sequence s_trig;
    wr_only && msr_addr == 32'h79 && !load_busy;
  endsequence
  sequence s_fetch_end;
    load_busy && $fell(mem_req);
  endsequence
  a_ack_follows: assert property ((msr_rd || msr_wr) |=> msr_ack)
    else $error("no ack");
  a_ack_cause: assert property (msr_ack |-> $past(msr_rd) || $past(msr_wr))
    else $error("stray ack");
  a_plat_rsvd: assert property (s_plat_rd |-> !msr_fault &&
    msr_rdata[63:53] == 11'h0 && msr_rdata[49:0] == 50'h0)
    else $error("reserved bits set");
  a_plat_code: assert property (s_plat_rd ##0
    ($past(platform_pins, 4) == platform_pins)
    |-> msr_rdata[52:50] == platform_pins) else $error("bad code");
  a_wr17_quiet: assert property (wr_only && msr_addr == 32'h17
    |=> !msr_fault) else $error("write to 17h faulted");
  a_trig_start: assert property (s_trig |=> mem_req && load_busy &&
    mem_addr == $past(base)) else $error("load did not start");
  a_req_hold: assert property (mem_req && !mem_valid && !mem_err
    |=> mem_req && $stable(mem_addr)) else $error("request dropped");
  a_addr_step: assert property (mem_req && mem_valid && !mem_err
    |=> !mem_req || mem_addr == $past(mem_addr) + 32'h4)
    else $error("bad address step");
  a_check_done: assert property (s_fetch_end |=> load_done)
    else $error("no done after fetch");
  a_err_length: assert property (load_busy && mem_req && mem_err
    |-> ##2 load_done && load_result == 3'h1) else $error("no length fail");
endmodule // pbh_loader_asserts

/* pbh_mem_model.sv */
`timescale 1ns/100ps
module pbh_mem_model (
  // Clock.
  input  wire        mclk,
  // Read port.
  input  wire        mem_req,
  input  wire [31:0] mem_addr,
  output reg         mem_valid,
  output reg         mem_err,
  output reg  [31:0] mem_data
);
  reg     [31:0] blk [0:511];
  reg     [31:0] base = 32'h0;
  reg     [31:0] idx;
  integer        lat = 0;
  integer        err_idx = -1;
  integer        cnt = 0;
  initial begin
    mem_valid = 1'b0;
    mem_err = 1'b0;
    mem_data = 32'h0;
  end
  // Data is scrambled whenever no word is offered.
  always @(posedge mclk) begin
    mem_valid <= 1'b0;
    mem_err <= 1'b0;
    mem_data <= ~mem_data;
    if (mem_req && !mem_valid && !mem_err) begin
      idx = (mem_addr - base) >> 2;
      if (cnt < lat)
        cnt <= cnt + 1;
      else if (idx == err_idx || idx > 32'h1ff) begin
        cnt <= 0;
        mem_err <= 1'b1;
      end else begin
        cnt <= 0;
        mem_valid <= 1'b1;
        mem_data <= blk[idx[8:0]];
      end
    end
  end
endmodule // pbh_mem_model

/* patch_block_header_check_bench.sv */
`timescale 1ns/100ps
module patch_block_header_check_bench;
  // Processor identity; the value is arbitrary.
  localparam [31:0] SIG = 32'h0000_0a51;
  localparam [26:0] EXP = {3'h1, 3'h2, 3'h5, 3'h4, 3'h3, 3'h3, 9'h0};
  reg         mclk = 1'b0;
  reg         nrst = 1'b0;
  reg         msr_rd = 1'b0;
  reg         msr_wr = 1'b0;
  reg         ident_op = 1'b0;
  reg  [31:0] msr_addr = 32'h0;
  reg  [63:0] msr_wdata = 64'h0;
  reg  [2:0]  platform_pins = 3'h0;
  wire [63:0] msr_rdata;
  wire [31:0] mem_addr, mem_data, active_revision;
  wire [2:0]  load_result;
  wire        msr_ack, msr_fault, mem_req, mem_valid, mem_err;
  wire        load_busy, load_done, patch_active;
  reg  [63:0] rdv;
  reg  [31:0] last;
  reg         fltv;
  integer     n_errors = 0;
  integer     compares = 0;
  integer     cyc = 0;

  pbh_patch_loader DUT (.mclk, .nrst, .msr_rd, .msr_wr, .msr_addr,
    .msr_wdata, .msr_rdata, .msr_ack, .msr_fault, .ident_op,
    .cpu_signature(SIG), .platform_pins, .mem_req, .mem_addr, .mem_valid,
    .mem_err, .mem_data, .load_busy, .load_done, .load_result,
    .patch_active, .active_revision);
  pbh_mem_model mem (.mclk, .mem_req, .mem_addr, .mem_valid, .mem_err,
    .mem_data);

  always #2 mclk = ~mclk;

  task print_verdict;
    begin
      if (n_errors == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end

  task check(input [63:0] seen, input [63:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task model_specific_register(input rd, input [31:0] a, input [63:0] d);
    begin
      @(negedge mclk);
      msr_rd = rd;
      msr_wr = !rd;
      msr_addr = a;
      msr_wdata = d;
      @(negedge mclk);
      msr_rd = 1'b0;
      msr_wr = 1'b0;
      rdv = msr_rdata;
      fltv = msr_fault;
      check(msr_ack, 1'b1);
    end
  endtask

  task ident(input [63:0] pre);
    begin
      model_specific_register(1'b0, 32'h8b, pre);
      ident_op = 1'b1;
      @(negedge mclk);
      ident_op = 1'b0;
      model_specific_register(1'b1, 32'h8b, 64'h0);
    end
  endtask

  task build(input [31:0] rev);
    integer i;
    begin
      for (i = 0; i < 512; i = i + 1)
        mem.blk[i] = i * 32'h0100_0193;
      mem.blk[0] = 32'h1;
      mem.blk[1] = rev;
      mem.blk[2] = 32'h0718_2003;
      mem.blk[3] = SIG;
      mem.blk[5] = 32'h1;
      mem.blk[6] = 32'h20;
    end
  endtask

  task fix;
    integer i;
    reg [31:0] s;
    begin
      s = 32'h0;
      mem.blk[4] = 32'h0;
      for (i = 0; i < 512; i = i + 1)
        s = s + mem.blk[i];
      mem.blk[4] = -s;
    end
  endtask

  task load(input [31:0] a);
    integer n;
    begin
      mem.base = a;
      model_specific_register(1'b0, 32'h79, {32'hffff_ffff, a});
      check(fltv, 1'b0);
      model_specific_register(1'b0, 32'h79, 64'h0);
      check(fltv, 1'b1);
      n = 0;
      while (load_done !== 1'b1 && n < 3000) begin
        @(negedge mclk);
        n = n + 1;
      end
      check(load_done, 1'b1);
    end
  endtask

  task plat_test;
    integer c;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        platform_pins = c[2:0];
        repeat (4) @(negedge mclk);
        model_specific_register(1'b0, 32'h17, ~64'h0);
        check(fltv, 1'b0);
        model_specific_register(1'b1, 32'h17, 64'h0);
        check(rdv, {11'h0, c[2:0], 50'h0});
      end
      model_specific_register(1'b1, 32'h44, 64'h0);
      check(fltv, 1'b1);
      model_specific_register(1'b1, 32'h79, 64'h0);
      check(fltv, 1'b1);
      check(rdv, 64'h0);
      model_specific_register(1'b0, 32'h44, 64'h0);
      check(fltv, 1'b1);
    end
  endtask

  task block_tests;
    integer k;
    begin
      ident(64'h1234);
      check(rdv, 64'h1234);
      check(patch_active, 1'b0);
      for (k = 0; k < 9; k = k + 1) begin
        mem.lat = k % 3;
        mem.err_idx = (k == 8) ? 300 : -1;
        platform_pins = (k == 1) ? 3'h2 : 3'h5;
        build(32'h100 + k);
        case (k)
          1: mem.blk[6] = 32'h4;
          2: mem.blk[9] = 32'hdead_beef;
          3: mem.blk[0] = 32'h2;
          4: mem.blk[5] = 32'h2;
          5: mem.blk[3] = SIG ^ 32'h1;
          6: mem.blk[6] = 32'hffff_ffdf;
          default: ;
        endcase
        fix;
        if (k == 7) mem.blk[77] = mem.blk[77] + 32'h1;
        load(32'h0001_0000 + k * 32'h1003);
        check(load_result, EXP[k*3 +: 3]);
        if (EXP[k*3 +: 3] == 3'h0) last = 32'h100 + k;
        check(active_revision, last);
        check(patch_active, 1'b1);
      end
      ident(64'h0);
      check(rdv, {last, 32'h0});
    end
  endtask

  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    plat_test;
    block_tests;
    print_verdict;
  end
endmodule // patch_block_header_check_bench

bind pbh_patch_loader pbh_loader_asserts chk (.mclk, .nrst, .msr_rd, .msr_wr,
  .msr_addr, .msr_wdata, .msr_rdata, .msr_ack, .msr_fault, .platform_pins,
  .mem_req, .mem_addr, .mem_valid, .mem_err, .load_busy, .load_done,
  .load_result);
